/* File: inc/stu_link_if.sv */
// Link between the clip-side partner and the setup unit state decode.
// Both ends run on clk_sys; no clocking block, the testbench joins them.
`timescale 1ns/1ps
interface stu_link_if;
    logic desc_wr;
    logic desc_sel;
    logic [31:0] desc_data;
    logic fence;
    logic [31:0] gsba;
    logic prim_valid;
    stu_pkg::stu_prim_t prim_type;
    logic prim_ccw;
    logic res_valid;
    stu_pkg::stu_prim_t res_type;
    logic res_front;
    logic res_xform;
    logic vp_fetch_req;
    logic [31:0] vp_fetch_addr;
    logic [31:0] clip_prim_counter;
    logic [4:0] active_size;
    logic [7:0] active_count;
    logic [12:0] active_units;
    logic count_err;
    logic mbz_err;

    modport device (
        input desc_wr, desc_sel, desc_data, fence, gsba, prim_valid, prim_type, prim_ccw,
        output res_valid, res_type, res_front, res_xform, vp_fetch_req, vp_fetch_addr,
        output clip_prim_counter, active_size, active_count, active_units, count_err, mbz_err
    );
    modport host (
        output desc_wr, desc_sel, desc_data, fence, gsba, prim_valid, prim_type, prim_ccw,
        input res_valid, res_type, res_front, res_xform, vp_fetch_req, vp_fetch_addr,
        input clip_prim_counter, active_size, active_count, active_units, count_err, mbz_err
    );
endinterface

/* File: inc/stu_pkg.sv */
// Constants for the setup unit state decode and its clip-side partner.
// Assumes a single 200 MHz clock shared by both ends.
package stu_pkg;
    // Descriptor word selects on the link
    localparam logic SEL_SIZING = 1'h0;
    localparam logic SEL_VIEWPORT = 1'h1;
    // Sizing word fields
    localparam int SIZE_LSB = 19;
    localparam int SIZE_MSB = 23;
    localparam int COUNT_LSB = 11;
    localparam int COUNT_MSB = 18;
    localparam int STAT_BIT = 10;
    localparam logic [31:0] SIZING_MBZ_MASK = 32'hFF0003FF;
    // Viewport word fields
    localparam int VP_OFF_LSB = 5;
    localparam int VP_OFF_MSB = 31;
    localparam int VP_XFORM_BIT = 1;
    localparam int VP_WIND_BIT = 0;
    localparam logic [31:0] VIEWPORT_MBZ_MASK = 32'h0000001C;
    // Units and limits
    localparam int UNIT_BITS = 512;
    localparam logic [7:0] COUNT_MIN = 8'h01;
    localparam logic [7:0] COUNT_MAX = 8'h40;
    // Reset values of the applied sizing
    localparam logic [4:0] SIZE_RST = 5'h00;
    localparam logic [7:0] COUNT_RST = 8'h01;
    localparam logic [12:0] UNITS_RST = 13'h0001;
    // Winding encodings
    localparam logic WINDING_CLOCKWISE = 1'h0;
    localparam logic WINDING_COUNTERCLOCKWISE = 1'h1;
    // Primitive kinds
    typedef enum logic [1:0] {
        PRIM_POINT = 2'h0,
        PRIM_LINE = 2'h1,
        PRIM_TRIANGLE = 2'h2
    } stu_prim_t;
    // Host register offsets (word index on the software port)
    localparam logic [3:0] REG_SIZING = 4'h0;
    localparam logic [3:0] REG_VIEWPORT = 4'h1;
    localparam logic [3:0] REG_GSBA = 4'h2;
    localparam logic [3:0] REG_FENCE = 4'h3;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_PRIM = 4'h5;
    localparam logic [3:0] REG_COUNT = 4'h6;
    localparam logic [3:0] REG_STATUS = 4'h7;
    localparam logic [3:0] REG_FETCH = 4'h8;
    // Host control bits
    localparam int CTRL_CLIP_EN = 0;
    localparam int CTRL_CLIP_STATS = 1;
endpackage

/* File: rtl/stu_clip_side.sv */
// Clip-side partner: turns software register writes into link traffic.
// Assumes a plain software port on clk_sys, read data one cycle after the strobe.
`timescale 1ns/1ps
module stu_clip_side (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    stu_link_if.host link
);
    ////////////////////////////////////////////////////////////////////////////
    // Control and link drive
    logic [1:0] ctrl_r;
    logic [31:0] gsba_r;
    logic desc_wr_r;
    logic desc_sel_r;
    logic [31:0] desc_data_r;
    logic fence_r;
    logic prim_valid_r;
    stu_pkg::stu_prim_t prim_type_r;
    logic prim_ccw_r;
    logic [31:0] fetch_addr_r;
    logic [31:0] rdata_r;
    logic stat_bit;

    // Statistics only when clipping and clip statistics are both on
    assign stat_bit = ctrl_r[stu_pkg::CTRL_CLIP_EN] && ctrl_r[stu_pkg::CTRL_CLIP_STATS];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_r <= 2'h0;
            gsba_r <= 32'h00000000;
        end else if (sw_wr) begin
            if (sw_addr == stu_pkg::REG_CTRL) begin
                ctrl_r <= sw_wdata[1:0];
            end
            if (sw_addr == stu_pkg::REG_GSBA) begin
                // A 32-bit base keeps viewport data below 4G
                gsba_r <= sw_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            desc_wr_r <= 1'b0;
            desc_sel_r <= stu_pkg::SEL_SIZING;
            desc_data_r <= 32'h00000000;
        end else begin
            desc_wr_r <= sw_wr && ((sw_addr == stu_pkg::REG_SIZING)
                || (sw_addr == stu_pkg::REG_VIEWPORT));
            if (sw_wr && (sw_addr == stu_pkg::REG_SIZING)) begin
                desc_sel_r <= stu_pkg::SEL_SIZING;
                desc_data_r <= {sw_wdata[31:stu_pkg::STAT_BIT + 1], stat_bit,
                    sw_wdata[stu_pkg::STAT_BIT - 1:0]};
            end else if (sw_wr && (sw_addr == stu_pkg::REG_VIEWPORT)) begin
                desc_sel_r <= stu_pkg::SEL_VIEWPORT;
                desc_data_r <= sw_wdata;
            end
        end
    end

    // Fence and primitive strobes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fence_r <= 1'b0;
            prim_valid_r <= 1'b0;
            prim_type_r <= stu_pkg::PRIM_POINT;
            prim_ccw_r <= 1'b0;
        end else begin
            fence_r <= sw_wr && (sw_addr == stu_pkg::REG_FENCE);
            prim_valid_r <= sw_wr && (sw_addr == stu_pkg::REG_PRIM);
            if (sw_wr && (sw_addr == stu_pkg::REG_PRIM)) begin
                prim_type_r <= stu_pkg::stu_prim_t'(sw_wdata[1:0]);
                prim_ccw_r <= sw_wdata[2];
            end
        end
    end

    // Last viewport fetch address seen
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fetch_addr_r <= 32'h00000000;
        end else if (link.vp_fetch_req) begin
            fetch_addr_r <= link.vp_fetch_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_r <= 32'h00000000;
        end else if (sw_rd) begin
            unique case (sw_addr)
                stu_pkg::REG_GSBA: rdata_r <= gsba_r;
                stu_pkg::REG_CTRL: rdata_r <= {30'h00000000, ctrl_r};
                stu_pkg::REG_COUNT: rdata_r <= link.clip_prim_counter;
                stu_pkg::REG_STATUS: rdata_r <= {3'h0, link.mbz_err, link.count_err,
                    link.active_units, link.active_count, 1'h0, link.active_size};
                stu_pkg::REG_FETCH: rdata_r <= fetch_addr_r;
                default: rdata_r <= 32'h00000000;
            endcase
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign sw_rdata = rdata_r;
    assign link.desc_wr = desc_wr_r;
    assign link.desc_sel = desc_sel_r;
    assign link.desc_data = desc_data_r;
    assign link.fence = fence_r;
    assign link.gsba = gsba_r;
    assign link.prim_valid = prim_valid_r;
    assign link.prim_type = prim_type_r;
    assign link.prim_ccw = prim_ccw_r;
endmodule

/* File: rtl/stu_face.sv */
// Facing decision for one primitive from its screen-space orientation.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module stu_face (
    input wire stu_pkg::stu_prim_t prim_type,
    input wire logic prim_ccw,
    input wire logic winding,
    output logic front
);
    always_comb begin
        if (prim_type == stu_pkg::PRIM_TRIANGLE) begin
            // Clockwise front when winding is 0, counter-clockwise when 1
            front = (winding == stu_pkg::WINDING_COUNTERCLOCKWISE)
                ? prim_ccw : !prim_ccw;
        end else begin
            // Points and lines always count as front
            front = 1'b1;
        end
    end
endmodule

/* File: rtl/stu_setup_decode.sv */
// Setup unit state decode: device end of the link.
// Assumes the partner writes descriptor words and fences over stu_link_if on clk_sys.
`timescale 1ns/1ps
module stu_setup_decode (
    input wire logic clk_sys,
    input wire logic srst,
    stu_link_if.device link
);
    ////////////////////////////////////////////////////////////////////////////
    // Field decoding
    function automatic logic [4:0] entry_size(input logic [31:0] word);
        entry_size = word[stu_pkg::SIZE_MSB:stu_pkg::SIZE_LSB];
    endfunction

    function automatic logic [7:0] entry_count(input logic [31:0] word);
        entry_count = word[stu_pkg::COUNT_MSB:stu_pkg::COUNT_LSB];
    endfunction

    function automatic logic count_legal(input logic [7:0] count);
        count_legal = (count >= stu_pkg::COUNT_MIN) && (count <= stu_pkg::COUNT_MAX);
    endfunction

    function automatic logic mbz_set(input logic [31:0] word, input logic [31:0] mask);
        mbz_set = (word & mask) != 32'h00000000;
    endfunction

    function automatic logic [26:0] vp_offset(input logic [31:0] word);
        vp_offset = word[stu_pkg::VP_OFF_MSB:stu_pkg::VP_OFF_LSB];
    endfunction

    function automatic logic [12:0] units_total(input logic [7:0] count, input logic [4:0] size);
        // Size field holds units minus one
        units_total = 13'(count) * (13'(size) + 13'h0001);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor state
    logic [4:0] pend_size_r;
    logic [7:0] pend_count_r;
    logic [4:0] act_size_r;
    logic [7:0] act_count_r;
    logic [12:0] act_units_r;
    logic stat_en_r;
    logic xform_en_r;
    logic winding_r;
    logic count_err_r;
    logic mbz_err_r;
    logic sizing_wr;
    logic viewport_wr;
    logic [7:0] new_count;
    logic count_ok;

    assign sizing_wr = link.desc_wr && (link.desc_sel == stu_pkg::SEL_SIZING);
    assign viewport_wr = link.desc_wr && (link.desc_sel == stu_pkg::SEL_VIEWPORT);
    assign new_count = entry_count(link.desc_data);
    assign count_ok = count_legal(new_count);

    // Pending size is captured on the descriptor write, the count only when it is legal
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pend_size_r <= stu_pkg::SIZE_RST;
            pend_count_r <= stu_pkg::COUNT_RST;
        end else if (sizing_wr) begin
            pend_size_r <= entry_size(link.desc_data);
            if (count_ok) begin
                pend_count_r <= new_count;
            end
        end
    end

    // Pending sizing becomes active only at a fence
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            act_size_r <= stu_pkg::SIZE_RST;
            act_count_r <= stu_pkg::COUNT_RST;
            act_units_r <= stu_pkg::UNITS_RST;
        end else if (link.fence) begin
            act_size_r <= pend_size_r;
            act_count_r <= pend_count_r;
            // Total allocation in 512-bit units: count times (size + 1)
            act_units_r <= units_total(pend_count_r, pend_size_r);
        end
    end

    // Statistics enable applies at once
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stat_en_r <= 1'b0;
        end else if (sizing_wr) begin
            stat_en_r <= link.desc_data[stu_pkg::STAT_BIT];
        end
    end

    // Viewport word
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            xform_en_r <= 1'b0;
            winding_r <= stu_pkg::WINDING_CLOCKWISE;
        end else if (viewport_wr) begin
            xform_en_r <= link.desc_data[stu_pkg::VP_XFORM_BIT];
            winding_r <= link.desc_data[stu_pkg::VP_WIND_BIT];
        end
    end

    // Error flags, sticky until reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count_err_r <= 1'b0;
            mbz_err_r <= 1'b0;
        end else begin
            if (sizing_wr && !count_ok) begin
                count_err_r <= 1'b1;
            end
            if ((sizing_wr && mbz_set(link.desc_data, stu_pkg::SIZING_MBZ_MASK))
                || (viewport_wr && mbz_set(link.desc_data, stu_pkg::VIEWPORT_MBZ_MASK))) begin
                mbz_err_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Viewport state fetch
    logic vp_fetch_req_r;
    logic [31:0] vp_fetch_addr_r;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            vp_fetch_req_r <= 1'b0;
            vp_fetch_addr_r <= 32'h00000000;
        end else begin
            vp_fetch_req_r <= viewport_wr;
            if (viewport_wr) begin
                // Base plus 32-byte aligned offset, wrapping in 32 bits
                vp_fetch_addr_r <= link.gsba + {vp_offset(link.desc_data), 5'h00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Primitive path
    logic face_front;
    logic res_valid_r;
    stu_pkg::stu_prim_t res_type_r;
    logic res_front_r;
    logic res_xform_r;
    logic [31:0] counter_r;

    stu_face stu_face_i (
        .prim_type(link.prim_type),
        .prim_ccw(link.prim_ccw),
        .winding(winding_r),
        .front(face_front)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            res_valid_r <= 1'b0;
            res_type_r <= stu_pkg::PRIM_POINT;
            res_front_r <= 1'b0;
            res_xform_r <= 1'b0;
        end else begin
            res_valid_r <= link.prim_valid;
            if (link.prim_valid) begin
                res_type_r <= link.prim_type;
                res_front_r <= face_front;
                res_xform_r <= xform_en_r;
            end
        end
    end

    // Clip primitive counter kept for the clip stage
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            counter_r <= 32'h00000000;
        end else if (link.prim_valid && stat_en_r) begin
            counter_r <= counter_r + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign link.res_valid = res_valid_r;
    assign link.res_type = res_type_r;
    assign link.res_front = res_front_r;
    assign link.res_xform = res_xform_r;
    assign link.vp_fetch_req = vp_fetch_req_r;
    assign link.vp_fetch_addr = vp_fetch_addr_r;
    assign link.clip_prim_counter = counter_r;
    assign link.active_size = act_size_r;
    assign link.active_count = act_count_r;
    assign link.active_units = act_units_r;
    assign link.count_err = count_err_r;
    assign link.mbz_err = mbz_err_r;
endmodule

/* File: tb/setup_unit_state_decode_tb.sv */
// Testbench: clip side and setup decode joined by one link.
// Assumes the software port timing of the clip side; no partner model.
`timescale 1ns/1ps
`define CHK(a, e) begin \
    n_tests++; \
    if ((a) !== (e)) begin \
        n_mismatch++; \
        $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); \
    end \
end
module setup_unit_state_decode_tb;
    typedef struct {
        logic wind;
        logic xf;
        stu_pkg::stu_prim_t typ;
        logic ccw;
        logic front;
    } stu_row_t;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h00000000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    logic [31:0] rdat;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    stu_row_t rows [6] = '{
        '{1'b0, 1'b1, stu_pkg::PRIM_TRIANGLE, 1'b0, 1'b1},
        '{1'b0, 1'b0, stu_pkg::PRIM_TRIANGLE, 1'b1, 1'b0},
        '{1'b1, 1'b1, stu_pkg::PRIM_TRIANGLE, 1'b1, 1'b1},
        '{1'b1, 1'b0, stu_pkg::PRIM_TRIANGLE, 1'b0, 1'b0},
        '{1'b1, 1'b1, stu_pkg::PRIM_POINT, 1'b0, 1'b1},
        '{1'b0, 1'b0, stu_pkg::PRIM_LINE, 1'b1, 1'b1}};
    stu_link_if link ();
    stu_setup_decode stu_setup_decode_i (.clk_sys(clk_sys), .srst(srst), .link(link.device));
    stu_clip_side stu_clip_side_i (.clk_sys(clk_sys), .srst(srst), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link.host));
    stu_link_properties stu_link_properties_i (.clk_sys(clk_sys), .srst(srst),
        .desc_wr(link.desc_wr), .desc_sel(link.desc_sel), .desc_data(link.desc_data),
        .fence(link.fence), .gsba(link.gsba), .prim_valid(link.prim_valid),
        .prim_type(link.prim_type), .prim_ccw(link.prim_ccw), .res_valid(link.res_valid),
        .res_front(link.res_front), .res_xform(link.res_xform),
        .vp_fetch_req(link.vp_fetch_req), .vp_fetch_addr(link.vp_fetch_addr),
        .clip_prim_counter(link.clip_prim_counter), .active_size(link.active_size),
        .active_count(link.active_count), .active_units(link.active_units),
        .count_err(link.count_err));
////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
    endtask
    // Two idle edges first so earlier link updates have landed
    task automatic rd(input logic [3:0] a);
        repeat (2) @(posedge clk_sys);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1;
        rdat = sw_rdata;
    endtask
    task automatic prim(input stu_pkg::stu_prim_t t, input logic c);
        wr(stu_pkg::REG_PRIM, {29'h00000000, c, t});
        @(posedge clk_sys);
        #1;
    endtask
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            give_verdict();
        end
    end
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        wr(stu_pkg::REG_GSBA, 32'hFFFFFF00);
        foreach (rows[i]) begin
            wr(stu_pkg::REG_VIEWPORT, {27'h7FFFFF0 + 27'(i), 3'h0, rows[i].xf, rows[i].wind});
            rd(stu_pkg::REG_FETCH);
            `CHK(rdat, 32'hFFFFFF00 + {27'h7FFFFF0 + 27'(i), 5'h00});
            prim(rows[i].typ, rows[i].ccw);
            `CHK(link.res_valid, 1'b1);
            `CHK(link.res_type, rows[i].typ);
            `CHK(link.res_front, rows[i].front);
            `CHK(link.res_xform, rows[i].xf);
        end
        // Largest size and count, seen only after the fence
        wr(stu_pkg::REG_SIZING, 32'h00FA0000);
        rd(stu_pkg::REG_STATUS);
        `CHK(rdat, 32'h00004040);
        wr(stu_pkg::REG_FENCE, 32'h00000000);
        rd(stu_pkg::REG_STATUS);
        `CHK(rdat, 32'h0200101F);
        wr(stu_pkg::REG_SIZING, 32'h00000000);
        wr(stu_pkg::REG_FENCE, 32'h00000000);
        rd(stu_pkg::REG_STATUS);
        `CHK(rdat, 32'h08101000);
        wr(stu_pkg::REG_CTRL, 32'h00000003);
        wr(stu_pkg::REG_SIZING, 32'h00000800);
        prim(stu_pkg::PRIM_TRIANGLE, 1'b0);
        prim(stu_pkg::PRIM_LINE, 1'b1);
        rd(stu_pkg::REG_COUNT);
        `CHK(rdat, 32'h00000002);
        wr(stu_pkg::REG_CTRL, 32'h00000001);
        wr(stu_pkg::REG_SIZING, 32'h00000800);
        prim(stu_pkg::PRIM_TRIANGLE, 1'b0);
        rd(stu_pkg::REG_COUNT);
        `CHK(rdat, 32'h00000002);
        // Reserved viewport bits flag but the word is still used
        wr(stu_pkg::REG_VIEWPORT, 32'h0000001C);
        rd(stu_pkg::REG_STATUS);
        `CHK(rdat, 32'h18101000);
        rd(stu_pkg::REG_FETCH);
        `CHK(rdat, 32'hFFFFFF00);
        // Second reset in mid-run
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (8) @(posedge clk_sys);
        srst <= 1'b0;
        rd(stu_pkg::REG_STATUS);
        `CHK(rdat, 32'h00004040);
        rd(stu_pkg::REG_COUNT);
        `CHK(rdat, 32'h00000000);
        prim(stu_pkg::PRIM_TRIANGLE, 1'b0);
        `CHK(link.res_front, 1'b1);
        `CHK(link.res_xform, 1'b0);
        give_verdict();
    end
endmodule

/* File: tb/stu_link_properties.sv */
// Concurrent checks on the link between the clip side and the setup decode.
// Assumes both ends share clk_sys and the synchronous active-high srst.
`timescale 1ns/1ps
module stu_link_properties (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic desc_wr,
    input wire logic desc_sel,
    input wire logic [31:0] desc_data,
    input wire logic fence,
    input wire logic [31:0] gsba,
    input wire logic prim_valid,
    input wire stu_pkg::stu_prim_t prim_type,
    input wire logic prim_ccw,
    input wire logic res_valid,
    input wire logic res_front,
    input wire logic res_xform,
    input wire logic vp_fetch_req,
    input wire logic [31:0] vp_fetch_addr,
    input wire logic [31:0] clip_prim_counter,
    input wire logic [4:0] active_size,
    input wire logic [7:0] active_count,
    input wire logic [12:0] active_units,
    input wire logic count_err
);
    logic [4:0] pend_size_r;
    logic [7:0] pend_count_r;
    logic wind_r;
    logic xform_r;
    logic stat_r;
    logic size_wr;
    logic count_ok;
    assign size_wr = desc_wr && (desc_sel == stu_pkg::SEL_SIZING);
    assign count_ok = desc_data[18:11] >= stu_pkg::COUNT_MIN
        && desc_data[18:11] <= stu_pkg::COUNT_MAX;
    // Sizing as the device should hold it pending a fence
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pend_size_r <= stu_pkg::SIZE_RST;
            pend_count_r <= stu_pkg::COUNT_RST;
            stat_r <= 1'b0;
        end else if (size_wr) begin
            pend_size_r <= desc_data[23:19];
            stat_r <= desc_data[10];
            if (count_ok) begin
                pend_count_r <= desc_data[18:11];
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wind_r <= stu_pkg::WINDING_CLOCKWISE;
            xform_r <= 1'b0;
        end else if (desc_wr && desc_sel == stu_pkg::SEL_VIEWPORT) begin
            wind_r <= desc_data[0];
            xform_r <= desc_data[1];
        end
    end
////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    sequence s_vp_word;
        desc_wr && desc_sel == stu_pkg::SEL_VIEWPORT;
    endsequence
    sequence s_tri;
        prim_valid && prim_type == stu_pkg::PRIM_TRIANGLE;
    endsequence
    property p_fetch;
        s_vp_word |=> vp_fetch_req
            && vp_fetch_addr == $past(gsba) + {$past(desc_data[31:5]), 5'h00};
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address wrong");
    property p_xform;
        prim_valid |=> res_valid && res_xform == $past(xform_r);
    endproperty
    a_xform: assert property (p_xform) else $error("transform flag wrong");
    property p_front;
        s_tri |=> res_front == ($past(prim_ccw) == $past(wind_r));
    endproperty
    a_front: assert property (p_front) else $error("triangle facing wrong");
    property p_flat;
        prim_valid && prim_type != stu_pkg::PRIM_TRIANGLE |=> res_front;
    endproperty
    a_flat: assert property (p_flat) else $error("point or line facing wrong");
    property p_stat_on;
        prim_valid && stat_r |=> clip_prim_counter == $past(clip_prim_counter) + 32'h00000001;
    endproperty
    a_stat_on: assert property (p_stat_on) else $error("counter not incremented");
    property p_stat_off;
        !(prim_valid && stat_r) |=> $stable(clip_prim_counter);
    endproperty
    a_stat_off: assert property (p_stat_off) else $error("counter moved");
    property p_fence;
        fence |=> active_size == $past(pend_size_r) && active_count == $past(pend_count_r);
    endproperty
    a_fence: assert property (p_fence) else $error("fence did not apply sizing");
    property p_units;
        active_units == {5'h00, active_count} * ({8'h00, active_size} + 13'h0001);
    endproperty
    a_units: assert property (p_units) else $error("unit total wrong");
    property p_count;
        size_wr && !count_ok |=> count_err;
    endproperty
    a_count: assert property (p_count) else $error("bad count not flagged");
endmodule
